// file: include/ocr_pkg.sv
// constants, field layout and carrier types of the output config registers
package ocr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register addresses and values after reset
    localparam logic [7:0] POS_CFG_ADDR = 8'h65;
    localparam logic [7:0] NEG_CFG_ADDR = 8'h66;
    localparam logic [7:0] DAC_A_CFG_ADDR = 8'h67;
    localparam logic [7:0] POS_CFG_RESET = 8'h20;
    localparam logic [7:0] NEG_CFG_RESET = 8'h20;
    localparam logic [7:0] DAC_A_CFG_RESET = 8'hc9;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // writable bits; the others are reserved and always hold zero
    localparam logic [7:0] POS_CFG_WMASK = 8'hf9;
    localparam logic [7:0] NEG_CFG_WMASK = 8'hfb;

    ////////////////////////////////////////////////////////////////////////
    // field positions; drive and level common to both side registers
    localparam int DRIVE_MSB = 7;
    localparam int DRIVE_LSB = 6;
    localparam int LEVEL_MSB = 5;
    localparam int LEVEL_LSB = 3;
    localparam int BW_BIT = 0;
    localparam int FULLSCALE_BIT = 1;
    localparam int CM_TOL_BIT = 0;

    // level codes; codes below 3'h4 are not to be written
    localparam logic [2:0] LEVEL_M8DB = 3'h4;
    localparam logic [2:0] LEVEL_M14DB = 3'h5;
    localparam logic [2:0] LEVEL_M20DB = 3'h6;
    localparam logic [2:0] LEVEL_M26DB = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // serial control port
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] FIRST_TX_BIT = 4'h1;
    localparam logic SYNC_IDLE = 1'b1;

    typedef enum logic [1:0] {
        OCR_DRV_LINE_OUT,
        OCR_DRV_HEADPHONE,
        OCR_DRV_FOUR_OHM,
        OCR_DRV_RECEIVER
    } ocr_drive_t;

    typedef struct packed {
        ocr_drive_t pos_side_drive_sel;
        logic [2:0] pos_side_level_code;
        logic dac_bandwidth_sel;
        ocr_drive_t neg_side_drive_sel;
        logic [2:0] neg_side_level_code;
        logic dac_fullscale_sel;
        logic common_mode_tolerance_sel;
        logic [7:0] dac_sub_a_config;
    } ocr_cfg_t;

endpackage

// file: src/ocr_sync_2ff.sv
// two flip-flop synchroniser for one pin input
`timescale 1ns/1ns
module ocr_sync_2ff #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

// file: src/ocr_output_cfg_regs.sv
// output driver config registers behind a serial two-wire target port
`timescale 1ns/1ns
// Functional notes
// - positive-side register at 0x65, reset 0x20, drive, level, bandwidth.
// - negative-side register at 0x66, reset 0x20, drive, level, scale, tol.
// - positive drive select resets 0: line, headphone, four-ohm, receiver.
// - positive level code resets 4; codes 4-7 are -8..-26 dB; avoid 0-3.
// - negative level code resets 4; codes 4-7 are -8..-26 dB; avoid 0-3.
// - reserved bits read zero; software writes only zero there.
// - positive bit 0 picks DAC bandwidth: 0 audio 24 kHz, 1 wide 96 kHz.
// - negative bit 0 picks coupling: 0 limited tolerance, 1 rail-to-rail.
module ocr_output_cfg_regs #(
    // target address, value arbitrary
    parameter logic [6:0] DEVICE_ADDR = 7'h2a
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output ocr_pkg::ocr_cfg_t cfg_o
);
    typedef enum {
        ST_IDLE, ST_DEVADDR, ST_ACK_ADDR, ST_REGPTR, ST_ACK_PTR,
        ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_RACK
    } ocr_state_t;
    logic scl_s;
    logic sda_s;
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    ocr_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic [7:0] ptr_ff;
    logic rw_ff;
    logic sda_oe_ff;
    logic wr_stb_ff;
    logic [7:0] wr_addr_ff;
    logic [7:0] wr_data_ff;
    logic [7:0] pos_cfg_ff;
    logic [7:0] neg_cfg_ff;
    logic [7:0] dac_a_cfg_ff;
    logic [7:0] rd_value;
    ////////////////////////////////////////////////////////////////////////
    // pin conditioning and bus events
    ocr_sync_2ff #(.RESET_VAL(ocr_pkg::SYNC_IDLE)) u_sync_scl (
        .clock_i(clock_i), .rst_i(rst_i), .d_i(scl_i), .q_o(scl_s)
    );
    ocr_sync_2ff #(.RESET_VAL(ocr_pkg::SYNC_IDLE)) u_sync_sda (
        .clock_i(clock_i), .rst_i(rst_i), .d_i(sda_i), .q_o(sda_s)
    );
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            scl_d_ff <= ocr_pkg::SYNC_IDLE;
            sda_d_ff <= ocr_pkg::SYNC_IDLE;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    // sda may only move while scl is high at a start or a stop
    assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    ////////////////////////////////////////////////////////////////////////
    // read multiplexer; unmapped addresses read zero
    always_comb begin
        case (ptr_ff)
            ocr_pkg::POS_CFG_ADDR: rd_value = pos_cfg_ff;
            ocr_pkg::NEG_CFG_ADDR: rd_value = neg_cfg_ff;
            ocr_pkg::DAC_A_CFG_ADDR: rd_value = dac_a_cfg_ff;
            default: rd_value = ocr_pkg::UNMAPPED_READ;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // serial target: address, pointer, auto-incremented data bytes
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            wr_stb_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_stb_ff <= 1'b0;
            if (bus_start) begin
                // a repeated start keeps the pointer for a read-back
                state_ff <= ST_DEVADDR;
                bit_cnt_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
            end else if (bus_stop) begin
                state_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_DEVADDR, ST_REGPTR, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda_s};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall &&
                                     bit_cnt_ff == ocr_pkg::BYTE_BITS) begin
                            bit_cnt_ff <= 4'h0;
                            if (state_ff == ST_DEVADDR) begin
                                if (shift_ff[7:1] == DEVICE_ADDR) begin
                                    rw_ff <= shift_ff[0];
                                    sda_oe_ff <= 1'b1;
                                    state_ff <= ST_ACK_ADDR;
                                end else begin
                                    state_ff <= ST_IDLE;
                                end
                            end else if (state_ff == ST_REGPTR) begin
                                ptr_ff <= shift_ff;
                                sda_oe_ff <= 1'b1;
                                state_ff <= ST_ACK_PTR;
                            end else begin
                                wr_stb_ff <= 1'b1;
                                wr_addr_ff <= ptr_ff;
                                wr_data_ff <= shift_ff;
                                ptr_ff <= ptr_ff + 8'h01;
                                sda_oe_ff <= 1'b1;
                                state_ff <= ST_ACK_WDATA;
                            end
                        end
                    end
                    ST_ACK_ADDR: begin
                        if (scl_fall) begin
                            if (rw_ff) begin
                                sda_oe_ff <= ~rd_value[7];
                                tx_ff <= {rd_value[6:0], 1'b0};
                                bit_cnt_ff <= ocr_pkg::FIRST_TX_BIT;
                                ptr_ff <= ptr_ff + 8'h01;
                                state_ff <= ST_RDATA;
                            end else begin
                                sda_oe_ff <= 1'b0;
                                state_ff <= ST_REGPTR;
                            end
                        end
                    end
                    ST_ACK_PTR, ST_ACK_WDATA: begin
                        if (scl_fall) begin
                            sda_oe_ff <= 1'b0;
                            state_ff <= ST_WDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (bit_cnt_ff == ocr_pkg::BYTE_BITS) begin
                                sda_oe_ff <= 1'b0;
                                state_ff <= ST_RACK;
                            end else begin
                                sda_oe_ff <= ~tx_ff[7];
                                tx_ff <= {tx_ff[6:0], 1'b0};
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise && sda_s) begin
                            // not acknowledged: end of read, wait for stop
                            state_ff <= ST_IDLE;
                        end else if (scl_fall) begin
                            sda_oe_ff <= ~rd_value[7];
                            tx_ff <= {rd_value[6:0], 1'b0};
                            bit_cnt_ff <= ocr_pkg::FIRST_TX_BIT;
                            ptr_ff <= ptr_ff + 8'h01;
                            state_ff <= ST_RDATA;
                        end
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_ff;
    ////////////////////////////////////////////////////////////////////////
    // register bank; forbidden level codes are stored as written, the
    // host is trusted to keep to codes 4 to 7
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pos_cfg_ff <= ocr_pkg::POS_CFG_RESET;
            neg_cfg_ff <= ocr_pkg::NEG_CFG_RESET;
            dac_a_cfg_ff <= ocr_pkg::DAC_A_CFG_RESET;
        end else if (wr_stb_ff) begin
            case (wr_addr_ff)
                ocr_pkg::POS_CFG_ADDR:
                    pos_cfg_ff <= wr_data_ff & ocr_pkg::POS_CFG_WMASK;
                ocr_pkg::NEG_CFG_ADDR:
                    neg_cfg_ff <= wr_data_ff & ocr_pkg::NEG_CFG_WMASK;
                ocr_pkg::DAC_A_CFG_ADDR:
                    dac_a_cfg_ff <= wr_data_ff;
                default: dac_a_cfg_ff <= dac_a_cfg_ff;
            endcase
        end
    end
    always_comb begin
        cfg_o.pos_side_drive_sel = ocr_pkg::ocr_drive_t'(
            pos_cfg_ff[ocr_pkg::DRIVE_MSB:ocr_pkg::DRIVE_LSB]);
        cfg_o.pos_side_level_code =
            pos_cfg_ff[ocr_pkg::LEVEL_MSB:ocr_pkg::LEVEL_LSB];
        cfg_o.dac_bandwidth_sel = pos_cfg_ff[ocr_pkg::BW_BIT];
        cfg_o.neg_side_drive_sel = ocr_pkg::ocr_drive_t'(
            neg_cfg_ff[ocr_pkg::DRIVE_MSB:ocr_pkg::DRIVE_LSB]);
        cfg_o.neg_side_level_code =
            neg_cfg_ff[ocr_pkg::LEVEL_MSB:ocr_pkg::LEVEL_LSB];
        cfg_o.dac_fullscale_sel = neg_cfg_ff[ocr_pkg::FULLSCALE_BIT];
        cfg_o.common_mode_tolerance_sel =
            neg_cfg_ff[ocr_pkg::CM_TOL_BIT];
        cfg_o.dac_sub_a_config = dac_a_cfg_ff;
    end
    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic wr_pos;
    logic wr_neg;
    assign wr_pos = wr_stb_ff && wr_addr_ff == ocr_pkg::POS_CFG_ADDR;
    assign wr_neg = wr_stb_ff && wr_addr_ff == ocr_pkg::NEG_CFG_ADDR;
    property p_pos_reset;
        $fell(rst_i) |-> cfg_o.pos_side_level_code == ocr_pkg::LEVEL_M8DB &&
            cfg_o.pos_side_drive_sel == ocr_pkg::OCR_DRV_LINE_OUT &&
            !cfg_o.dac_bandwidth_sel && pos_cfg_ff == ocr_pkg::POS_CFG_RESET;
    endproperty
    a_pos_reset: assert property (p_pos_reset) else $error("pos reset");
    property p_neg_reset;
        $fell(rst_i) |-> neg_cfg_ff == ocr_pkg::NEG_CFG_RESET &&
            cfg_o.neg_side_level_code == ocr_pkg::LEVEL_M8DB &&
            !cfg_o.dac_fullscale_sel && !cfg_o.common_mode_tolerance_sel;
    endproperty
    a_neg_reset: assert property (p_neg_reset) else $error("neg reset");
    property p_pos_drive;
        wr_pos |=> cfg_o.pos_side_drive_sel == $past(wr_data_ff[7:6]);
    endproperty
    a_pos_drive: assert property (p_pos_drive) else $error("pos drive");
    property p_pos_level_hold;
        !wr_pos |=> $stable(cfg_o.pos_side_level_code);
    endproperty
    a_pos_level_hold: assert property (p_pos_level_hold)
        else $error("pos level moved");
    property p_neg_drive;
        wr_neg |=> cfg_o.neg_side_drive_sel == $past(wr_data_ff[7:6]);
    endproperty
    a_neg_drive: assert property (p_neg_drive) else $error("neg drive");
    property p_neg_level;
        wr_neg |=> cfg_o.neg_side_level_code == $past(wr_data_ff[5:3]);
    endproperty
    a_neg_level: assert property (p_neg_level) else $error("neg level");
    property p_reserved_zero;
        wr_stb_ff |=> pos_cfg_ff[2:1] == 2'h0 && neg_cfg_ff[2] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit set");
    property p_bandwidth;
        wr_pos |=> cfg_o.dac_bandwidth_sel == $past(wr_data_ff[0]) ##1
            $stable(cfg_o.dac_bandwidth_sel) || $past(wr_pos);
    endproperty
    a_bandwidth: assert property (p_bandwidth) else $error("bandwidth");
    property p_cm_tol;
        wr_neg |=> cfg_o.common_mode_tolerance_sel == $past(wr_data_ff[0]);
    endproperty
    a_cm_tol: assert property (p_cm_tol) else $error("cm tolerance");
    property p_fullscale;
        !wr_neg |=> $stable(cfg_o.dac_fullscale_sel);
    endproperty
    a_fullscale: assert property (p_fullscale) else $error("fullscale");
    property p_addr_ack;
        state_ff == ST_DEVADDR && scl_fall && !bus_start && !bus_stop &&
            bit_cnt_ff == ocr_pkg::BYTE_BITS && shift_ff[7:1] == DEVICE_ADDR
            |=> sda_oe_o && state_ff == ST_ACK_ADDR;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("no address ack");
    c_pos_write: cover property (wr_pos);
    c_neg_write: cover property (wr_neg);
    c_read_byte: cover property (state_ff == ST_RACK ##[1:600]
        state_ff == ST_RDATA);
    c_read_nack: cover property (state_ff == ST_RACK ##1 state_ff == ST_IDLE);
endmodule

// file: tb/ocr_output_cfg_regs_tb.sv
// self-checking bench for the output config registers over the two-wire port
`timescale 1ns/1ns
module ocr_output_cfg_regs_tb;

    localparam logic [6:0] DEV = 7'h2a;
    localparam int LIMIT = 40000;

    logic clock_i;
    logic rst_i;
    logic scl;
    logic sda_drv;
    wire logic sda_line;
    logic sda_o;
    logic sda_oe_o;
    ocr_pkg::ocr_cfg_t cfg_o;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    // open-drain wire with pull-up: low if either party pulls
    assign sda_line = sda_drv & (sda_oe_o ? sda_o : 1'b1);

    ocr_output_cfg_regs #(.DEVICE_ADDR(DEV)) u_ocr_output_cfg_regs (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .scl_i(scl),
        .sda_i(sda_line),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .cfg_o(cfg_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(string what, logic exp, logic got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bus primitives; every phase lasts 8 clocks, data moves mid-low phase
    task automatic tick(int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic bus_start();
        tick(4);
        sda_drv = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_drv = 1'b0;
        tick(8);
        scl = 1'b0;
    endtask

    task automatic bus_stop();
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_drv = 1'b1;
        tick(8);
    endtask

    task automatic put_bit(logic b, output logic s);
        tick(4);
        sda_drv = b;
        tick(4);
        scl = 1'b1;
        tick(8);
        s = sda_line;
        scl = 1'b0;
    endtask

    task automatic put_byte(logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, ack);
    endtask

    task automatic get_byte(logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(last, s);
    endtask

    // write two bytes from ptr; every byte must be acknowledged
    task automatic reg_write(logic [7:0] ptr, logic [7:0] d0, logic [7:0] d1);
        logic a;
        bus_start();
        put_byte({DEV, 1'b0}, a);
        cmp1("address ack", 1'b0, a);
        put_byte(ptr, a);
        cmp1("pointer ack", 1'b0, a);
        put_byte(d0, a);
        cmp1("data ack", 1'b0, a);
        put_byte(d1, a);
        cmp1("data ack", 1'b0, a);
        bus_stop();
    endtask

    // read two bytes from ptr through a repeated start
    task automatic reg_read(logic [7:0] ptr, logic [7:0] e0, logic [7:0] e1);
        logic a;
        logic [7:0] d;
        bus_start();
        put_byte({DEV, 1'b0}, a);
        put_byte(ptr, a);
        bus_start();
        put_byte({DEV, 1'b1}, a);
        cmp1("read address ack", 1'b0, a);
        get_byte(1'b0, d);
        cmp8("read byte 0", e0, d);
        get_byte(1'b1, d);
        cmp8("read byte 1", e1, d);
        bus_stop();
    endtask

    task automatic check_cfg(logic [7:0] pos, logic [7:0] neg,
                             logic [7:0] dac);
        cmp8("pos cfg image", pos, {cfg_o.pos_side_drive_sel,
            cfg_o.pos_side_level_code, 2'b00, cfg_o.dac_bandwidth_sel});
        cmp8("neg cfg image", neg, {cfg_o.neg_side_drive_sel,
            cfg_o.neg_side_level_code, 1'b0, cfg_o.dac_fullscale_sel,
            cfg_o.common_mode_tolerance_sel});
        cmp8("dac sub a", dac, cfg_o.dac_sub_a_config);
    endtask

    task automatic do_reset();
        rst_i = 1'b1;
        tick(4);
        rst_i = 1'b0;
        tick(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_values();
        check_cfg(8'h20, 8'h20, 8'hc9);
        reg_read(8'h65, 8'h20, 8'h20);
        reg_read(8'h67, 8'hc9, 8'h00);
    endtask

    // every writable bit set; reserved bits are written only as zero
    task automatic t_reserved();
        reg_write(8'h65, 8'hf9, 8'hfb);
        check_cfg(8'hf9, 8'hfb, 8'hc9);
        reg_read(8'h65, 8'hf9, 8'hfb);
    endtask

    // every drive code and every legal level code on both sides
    task automatic t_codes();
        logic [7:0] p;
        logic [7:0] n;
        for (int i = 0; i < 4; i++) begin
            p = {i[1:0], 3'(4 + i), 2'b00, i[0]};
            n = {~i[1:0], 3'(7 - i), 1'b0, i[1], ~i[0]};
            reg_write(8'h65, p, n);
            check_cfg(p, n, 8'hc9);
            reg_read(8'h65, p, n);
        end
    endtask

    // writing past the last register is acknowledged but discarded
    task automatic t_dac_and_unmapped();
        reg_write(8'h67, 8'h3a, 8'h55);
        check_cfg(8'hf9, 8'h22, 8'h3a);
        reg_read(8'h67, 8'h3a, 8'h00);
    endtask

    task automatic t_wrong_address();
        logic a;
        bus_start();
        put_byte({DEV ^ 7'h01, 1'b0}, a);
        cmp1("foreign address ack", 1'b1, a);
        put_byte(8'h65, a);
        put_byte(8'h00, a);
        bus_stop();
        check_cfg(8'hf9, 8'h22, 8'h3a);
    endtask

    task automatic t_reset_again();
        do_reset();
        check_cfg(8'h20, 8'h20, 8'hc9);
        reg_read(8'h65, 8'h20, 8'h20);
    endtask

    initial begin
        rst_i = 1'b1;
        scl = 1'b1;
        sda_drv = 1'b1;
        do_reset();
        t_reset_values();
        t_reserved();
        t_codes();
        t_dac_and_unmapped();
        t_wrong_address();
        t_reset_again();
        stop_test();
    end

endmodule
